/* common/rsc_pkg.sv */
/*
  rsc_pkg: constants, register map, reset values and timing counts of the
  regulator set-point control block.
  Assumes a 100 MHz core clock and an 8-bit register port fed by the
  device's serial slave.
*/
// Behaviour
// - buck1 codes 11101, 11110, 11111 give 1.425 V, 1.800 V, 3.300 V
// - buck1 codes 0 to 29 give 0.7 V plus 25 mV per step
// - buck1 set point at 0x20, mode at 0x23, phase and frequency at 0x24
// - buck2 set point at 0x35, mode at 0x38, configuration at 0x39
// - buck3 set point at 0x3C, mode at 0x3F, configuration at 0x40
// - buck2 low range: 1.500 V plus 50 mV per code up to 1.850 V
// - buck2 range flag taken from start-up strap; host cannot change it; code captures the synchronizer's reset zero, so the flag stays 0
// - buck3 codes give 0.90 V plus 50 mV per step up to 1.65 V
// - a disabled LDO has its pull-down switched on
// - entering current limit sets the LDO fault flag regardless of shutdown enable
// - with shutdown enabled, current limit over 8.0 ms clears the LDO enable
// - each fault mask bit blocks that LDO's interrupt request
// - short-circuit shutdown enable resets to cleared
// - LDO one 1.80 V plus 0.10 V steps; LDO two 0.80 V plus 0.05 V steps
// - LDO three and four 1.80 V to 3.30 V in 0.10 V steps
// - high-rail LDO codes give 2.85, 3.00, 3.15, 3.30 V
// - card LDO uses 2.85 to 3.30 V or 1.80/1.85 V set by voltage select
// - LDO enable bit 0 off, 1 on, writable at any time
// - each LDO has one control register holding set point and enable
// - buck mode 0000 off, 0001 PWM, 0011 PFM, 1000 APS, APS at reset
// - buck frequency 00 1 MHz, 01 2 MHz, 10 4 MHz, 11 reserved, 01 at reset
// - buck output moves to a new set point 25 mV every 4.0 us
package rsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] RSC_ADDR_B1_VOLT   = 8'h20;
  localparam logic [7:0] RSC_ADDR_B1_MODE   = 8'h23;
  localparam logic [7:0] RSC_ADDR_B1_CONF   = 8'h24;
  localparam logic [7:0] RSC_ADDR_B2_VOLT   = 8'h35;
  localparam logic [7:0] RSC_ADDR_B2_MODE   = 8'h38;
  localparam logic [7:0] RSC_ADDR_B2_CONF   = 8'h39;
  localparam logic [7:0] RSC_ADDR_B3_VOLT   = 8'h3C;
  localparam logic [7:0] RSC_ADDR_B3_MODE   = 8'h3F;
  localparam logic [7:0] RSC_ADDR_B3_CONF   = 8'h40;
  localparam logic [7:0] RSC_ADDR_LDO_BASE  = 8'h70;  // six control registers, 0x70..0x75
  localparam logic [7:0] RSC_ADDR_FLT       = 8'h78;  // fault flags, write one to clear
  localparam logic [7:0] RSC_ADDR_MSK       = 8'h79;
  localparam logic [7:0] RSC_ADDR_SCP       = 8'h7A;
  localparam logic [7:0] RSC_ADDR_STAT      = 8'h7B;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int RSC_CONF_PHASE_LSB = 0;
  localparam int RSC_CONF_FREQ_LSB  = 2;
  localparam int RSC_CONF_ILIM_BIT  = 4;
  localparam int RSC_LDO_EN_BIT     = 4;
  localparam int RSC_STAT_HL_BIT    = 7;
  localparam logic [5:0][3:0] RSC_LDO_SP_MASK = {4'h3, 4'h3, 4'hF, 4'hF, 4'hF, 4'hF};

  ////////////////////////////////////////////////////////////////////////////
  // buck mode and frequency codes
  localparam logic [3:0] RSC_MODE_OFF   = 4'h0;
  localparam logic [3:0] RSC_MODE_PWM   = 4'h1;
  localparam logic [3:0] RSC_MODE_PFM   = 4'h3;
  localparam logic [3:0] RSC_MODE_APS   = 4'h8;
  localparam logic [1:0] RSC_FREQ_RSVD  = 2'h3;

  typedef enum logic [1:0] {
    RSC_BMODE_OFF = 2'b00,
    RSC_BMODE_PWM = 2'b01,
    RSC_BMODE_PFM = 2'b10,
    RSC_BMODE_APS = 2'b11
  } rsc_buck_mode_type;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [4:0]       RSC_B1_SP_RST  = 5'h00;
  localparam logic [2:0]       RSC_B2_SP_RST  = 3'h0;
  localparam logic [3:0]       RSC_B3_SP_RST  = 4'h0;
  localparam logic [3:0]       RSC_MODE_RST   = RSC_MODE_APS;
  localparam logic [1:0]       RSC_FREQ_RST   = 2'h1;
  localparam logic [2:0][1:0]  RSC_PHASE_RST  = {2'h2, 2'h1, 2'h0};  // buck3, buck2, buck1
  localparam logic [5:0]       RSC_MSK_RST    = 6'h3F;
  localparam logic [5:0]       RSC_LDO_EN_RST = 6'h00;
  localparam logic             RSC_SCP_RST    = 1'b0;
  localparam logic [2:0][11:0] RSC_BUCK_INIT_MV = {12'h384, 12'h5DC, 12'h2BC};
  localparam logic [5:0][11:0] RSC_LDO_RST_MV   = {12'hB22, 12'hB22, 12'h708, 12'h708, 12'h320, 12'h708};

  ////////////////////////////////////////////////////////////////////////////
  // millivolt constants of the decoders
  localparam logic [11:0] RSC_MV_B1_BASE = 12'h2BC;  // 700
  localparam logic [11:0] RSC_MV_25      = 12'h019;
  localparam logic [11:0] RSC_MV_50      = 12'h032;
  localparam logic [11:0] RSC_MV_100     = 12'h064;
  localparam logic [11:0] RSC_MV_150     = 12'h096;
  localparam logic [11:0] RSC_MV_1500    = 12'h5DC;
  localparam logic [11:0] RSC_MV_900     = 12'h384;
  localparam logic [11:0] RSC_MV_800     = 12'h320;
  localparam logic [11:0] RSC_MV_1800    = 12'h708;
  localparam logic [11:0] RSC_MV_1850    = 12'h73A;
  localparam logic [11:0] RSC_MV_2850    = 12'hB22;
  localparam logic [11:0] RSC_MV_3300    = 12'hCE4;
  localparam logic [7:0][11:0] RSC_B2_HIGH_MV =
    {12'hCE4, 12'hC80, 12'hC4E, 12'hC1C, 12'hBB8, 12'hB22, 12'hAF0, 12'h9C4};

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int RSC_CLK_PERIOD_NS  = 10;
  localparam int RSC_DVS_STEP_NS    = 4000;     // 4.0 us per 25 mV step
  localparam int RSC_DVS_STEP_CYC   = RSC_DVS_STEP_NS / RSC_CLK_PERIOD_NS;
  localparam int RSC_SCP_TIME_NS    = 8000000;  // 8.0 ms
  localparam int RSC_SCP_CYC        = RSC_SCP_TIME_NS / RSC_CLK_PERIOD_NS;

endpackage

/* rtl/rsc_dvs_ramp.sv */
/*
  rsc_dvs_ramp: walks one buck output code toward its target in fixed
  millivolt steps at a fixed step interval.
  Assumes a target that comes from a register on the same clock.
*/
`timescale 1ns/1ns
module rsc_dvs_ramp
  import rsc_pkg::*;
#(
  parameter logic [11:0] INIT_MV     = 12'h000,
  parameter logic [11:0] STEP_MV     = 12'h019,
  parameter int          STEP_CYCLES = 400
) (
  input  wire logic        mclk,        // core clock
  input  wire logic        rst_n,       // released reset
  input  wire logic [11:0] target_mv,   // requested output
  output logic      [11:0] out_mv,      // present output
  output logic             ramping      // high while out differs from target
);

  localparam int CW = $clog2(STEP_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [11:0]   mv;
    logic          busy;
  } rsc_ramp_type;

  rsc_ramp_type st_q;
  rsc_ramp_type st_d;

  ////////////////////////////////////////////////////////////////////////////
  // one step each interval; the last step may be short so the target is hit
  always_comb begin
    st_d = st_q;
    if (st_q.mv != target_mv) begin
      if (st_q.cnt == CW'(STEP_CYCLES - 1)) begin
        st_d.cnt = '0;
        if (target_mv > st_q.mv) begin
          st_d.mv = (target_mv - st_q.mv > STEP_MV) ? st_q.mv + STEP_MV : target_mv;
        end else begin
          st_d.mv = (st_q.mv - target_mv > STEP_MV) ? st_q.mv - STEP_MV : target_mv;
        end
      end else begin
        st_d.cnt = st_q.cnt + CW'(1);
      end
    end else begin
      st_d.cnt = '0;
    end
    st_d.busy = (st_d.mv != target_mv);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= '0;
      st_q.mv <= INIT_MV;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_mv  = st_q.mv;
  assign ramping = st_q.busy;

endmodule // rsc_dvs_ramp

/* rtl/rsc_regulator_ctrl.sv */
/*
  rsc_regulator_ctrl: register bank and decoders for three bucks and six
  LDOs, with LDO overcurrent flags, masks and timed shutdown.
  Assumes an 8-bit register port driven by the serial slave on mclk, and
  asynchronous analog pins for current limit, card voltage select and the
  buck2 start-up range strap.
*/
`timescale 1ns/1ns
module rsc_regulator_ctrl
  import rsc_pkg::*;
#(
  parameter int SCP_CYCLES = RSC_SCP_CYC,
  parameter int DVS_CYCLES = RSC_DVS_STEP_CYC
) (
  input  wire logic        mclk,               // 100 MHz core clock
  input  wire logic        arst_n,             // async reset, active low
  input  wire logic [7:0]  reg_addr,           // register offset
  input  wire logic [7:0]  reg_wdata,          // write data
  input  wire logic        reg_wr,             // write strobe
  input  wire logic        reg_rd,             // read strobe
  output logic      [7:0]  reg_rdata,          // read data, one cycle after reg_rd
  input  wire logic        buck2_startup_high, // start-up range strap pin
  input  wire logic [5:0]  ldo_current_limit,  // per-LDO current limit pins
  input  wire logic        card_voltage_select,// card LDO low-voltage select pin
  output logic [2:0][11:0] buck_target_mv,     // decoded set point per buck
  output logic [2:0][11:0] buck_vout_mv,       // ramped output per buck
  output logic [2:0]       buck_ramping,       // ramp in progress
  output logic [2:0][1:0]  buck_mode,          // decoded switching mode
  output logic [2:0][1:0]  buck_frequency,     // frequency code, never reserved
  output logic [2:0][1:0]  buck_phase,         // clock phase code
  output logic [2:0]       buck_ilim,          // current limit select
  output logic [5:0][11:0] ldo_target_mv,      // decoded LDO set point
  output logic [5:0]       ldo_on,             // LDO enable to analog
  output logic [5:0]       ldo_pulldown,       // discharge path enable
  output logic             ldo_fault_irq       // unmasked fault request
);

  localparam int TW = $clog2(SCP_CYCLES + 1);

  typedef struct packed {
    logic [5:0]          cl_s1;
    logic [5:0]          cl_s2;
    logic [5:0]          cl_s3;
    logic [5:0]          cl_lvl;
    logic [2:0]          vs_sy;
    logic                vsel;
    logic [2:0]          hs_sy;
    logic                hl;
    logic                hl_done;
    logic [4:0]          b1_sp;
    logic [2:0]          b2_sp;
    logic [3:0]          b3_sp;
    logic [2:0][3:0]     b_mode;
    logic [2:0][1:0]     b_freq;
    logic [2:0][1:0]     b_phase;
    logic [2:0]          b_ilim;
    logic [5:0][3:0]     ldo_sp;
    logic [5:0]          ldo_en;
    logic [5:0]          flt;
    logic [5:0]          msk;
    logic                scp_en;
    logic [5:0][TW-1:0]  tmr;
    logic [7:0]          rdata;
    logic [2:0][11:0]    b_tgt;
    logic [2:0][1:0]     mode_out;
    logic [2:0][1:0]     freq_out;
    logic [5:0][11:0]    ldo_mv;
    logic [5:0]          ldo_on;
    logic [5:0]          ldo_pd;
    logic                irq;
  } rsc_state_type;

  rsc_state_type st_q;
  rsc_state_type st_d;
  logic [1:0]    rst_sy_q;
  logic          rst_n;
  logic [7:0]    rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sy_q <= 2'h0;
    end else begin
      rst_sy_q <= {rst_sy_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sy_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // set-point decoders
  function automatic logic [11:0] buck_mv(int idx, logic [4:0] c, logic hl);
    logic [11:0] v;
    v = 12'h000;
    case (idx)
      0: begin
        if (c == 5'h1E) begin
          v = RSC_MV_1800;
        end else if (c == 5'h1F) begin
          v = RSC_MV_3300;
        end else begin
          v = RSC_MV_B1_BASE + RSC_MV_25 * {7'h00, c};
        end
      end
      1: begin
        if (hl) begin
          v = RSC_B2_HIGH_MV[c[2:0]];
        end else begin
          v = RSC_MV_1500 + RSC_MV_50 * {9'h000, c[2:0]};
        end
      end
      default: v = RSC_MV_900 + RSC_MV_50 * {8'h00, c[3:0]};
    endcase
    return v;
  endfunction

  function automatic logic [11:0] ldo_mv(int idx, logic [3:0] c, logic vsel);
    logic [11:0] v;
    v = 12'h000;
    case (idx)
      1:       v = RSC_MV_800 + RSC_MV_50 * {8'h00, c};
      4:       v = RSC_MV_2850 + RSC_MV_150 * {10'h000, c[1:0]};
      5: begin
        if (vsel) begin
          v = (c[1:0] == 2'h3) ? RSC_MV_1850 : RSC_MV_1800;
        end else begin
          v = RSC_MV_2850 + RSC_MV_150 * {10'h000, c[1:0]};
        end
      end
      default: v = RSC_MV_1800 + RSC_MV_100 * {8'h00, c};
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // read mux: unused bits and unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (reg_addr)
      RSC_ADDR_B1_VOLT: rd_data = {3'h0, st_q.b1_sp};
      RSC_ADDR_B2_VOLT: rd_data = {5'h00, st_q.b2_sp};
      RSC_ADDR_B3_VOLT: rd_data = {4'h0, st_q.b3_sp};
      RSC_ADDR_B1_MODE: rd_data = {4'h0, st_q.b_mode[0]};
      RSC_ADDR_B2_MODE: rd_data = {4'h0, st_q.b_mode[1]};
      RSC_ADDR_B3_MODE: rd_data = {4'h0, st_q.b_mode[2]};
      RSC_ADDR_B1_CONF: rd_data = {4'h0, st_q.b_freq[0], st_q.b_phase[0]};
      RSC_ADDR_B2_CONF: rd_data = {3'h0, st_q.b_ilim[1], st_q.b_freq[1], st_q.b_phase[1]};
      RSC_ADDR_B3_CONF: rd_data = {3'h0, st_q.b_ilim[2], st_q.b_freq[2], st_q.b_phase[2]};
      RSC_ADDR_FLT:     rd_data = {2'h0, st_q.flt};
      RSC_ADDR_MSK:     rd_data = {2'h0, st_q.msk};
      RSC_ADDR_SCP:     rd_data = {7'h00, st_q.scp_en};
      RSC_ADDR_STAT:    rd_data = {st_q.hl, 1'b0, st_q.cl_lvl};
      default: begin
        for (int i = 0; i < 6; i++) begin
          if (reg_addr == RSC_ADDR_LDO_BASE + 8'(i)) begin
            rd_data = {3'h0, st_q.ldo_en[i], st_q.ldo_sp[i]};
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole bank
  always_comb begin
    st_d = st_q;

    // pins: three flops, level moves once stages two and three agree
    st_d.cl_s1 = ldo_current_limit;
    st_d.cl_s2 = st_q.cl_s1;
    st_d.cl_s3 = st_q.cl_s2;
    for (int i = 0; i < 6; i++) begin
      if (st_q.cl_s2[i] == st_q.cl_s3[i]) begin
        st_d.cl_lvl[i] = st_q.cl_s3[i];
      end
    end
    st_d.vs_sy = {st_q.vs_sy[1:0], card_voltage_select};
    if (st_q.vs_sy[1] == st_q.vs_sy[2]) begin
      st_d.vsel = st_q.vs_sy[2];
    end
    st_d.hs_sy = {st_q.hs_sy[1:0], buck2_startup_high};

    // range flag set once, on the first cycle after reset, from stage three's reset zero; no register reaches it
    if (!st_q.hl_done && st_q.hs_sy[1] == st_q.hs_sy[2]) begin
      st_d.hl      = st_q.hs_sy[2];
      st_d.hl_done = 1'b1;
    end

    // host writes; fields narrower than eight bits drop the rest
    if (reg_wr) begin
      unique case (reg_addr)
        RSC_ADDR_B1_VOLT: st_d.b1_sp = reg_wdata[4:0];
        RSC_ADDR_B2_VOLT: st_d.b2_sp = reg_wdata[2:0];
        RSC_ADDR_B3_VOLT: st_d.b3_sp = reg_wdata[3:0];
        RSC_ADDR_B1_MODE: st_d.b_mode[0] = reg_wdata[3:0];
        RSC_ADDR_B2_MODE: st_d.b_mode[1] = reg_wdata[3:0];
        RSC_ADDR_B3_MODE: st_d.b_mode[2] = reg_wdata[3:0];
        RSC_ADDR_B1_CONF: begin
          st_d.b_phase[0] = reg_wdata[RSC_CONF_PHASE_LSB +: 2];
          st_d.b_freq[0]  = reg_wdata[RSC_CONF_FREQ_LSB +: 2];
        end
        RSC_ADDR_B2_CONF: begin
          st_d.b_phase[1] = reg_wdata[RSC_CONF_PHASE_LSB +: 2];
          st_d.b_freq[1]  = reg_wdata[RSC_CONF_FREQ_LSB +: 2];
          st_d.b_ilim[1]  = reg_wdata[RSC_CONF_ILIM_BIT];
        end
        RSC_ADDR_B3_CONF: begin
          st_d.b_phase[2] = reg_wdata[RSC_CONF_PHASE_LSB +: 2];
          st_d.b_freq[2]  = reg_wdata[RSC_CONF_FREQ_LSB +: 2];
          st_d.b_ilim[2]  = reg_wdata[RSC_CONF_ILIM_BIT];
        end
        RSC_ADDR_FLT:     st_d.flt = st_q.flt & ~reg_wdata[5:0];
        RSC_ADDR_MSK:     st_d.msk = reg_wdata[5:0];
        RSC_ADDR_SCP:     st_d.scp_en = reg_wdata[0];
        default: begin
          for (int i = 0; i < 6; i++) begin
            if (reg_addr == RSC_ADDR_LDO_BASE + 8'(i)) begin
              st_d.ldo_sp[i] = reg_wdata[3:0] & RSC_LDO_SP_MASK[i];
              st_d.ldo_en[i] = reg_wdata[RSC_LDO_EN_BIT];
            end
          end
        end
      endcase
    end

    // overcurrent: flag on entry, timed shutdown; both win over a same-cycle write
    for (int i = 0; i < 6; i++) begin
      if (st_d.cl_lvl[i] && !st_q.cl_lvl[i]) begin
        st_d.flt[i] = 1'b1;
      end
      if (st_q.cl_lvl[i] && st_q.ldo_en[i]) begin
        if (st_q.tmr[i] != TW'(SCP_CYCLES)) begin
          st_d.tmr[i] = st_q.tmr[i] + TW'(1);
        end else if (st_q.scp_en) begin
          st_d.ldo_en[i] = 1'b0;
          st_d.tmr[i]    = '0;
        end
      end else begin
        st_d.tmr[i] = '0;
      end
    end

    // read data holds until the next read
    if (reg_rd) begin
      st_d.rdata = rd_data;
    end

    // registered decodes driving the analog side
    for (int k = 0; k < 3; k++) begin
      st_d.b_tgt[k] = buck_mv(k, (k == 0) ? st_q.b1_sp :
                                 (k == 1) ? {2'h0, st_q.b2_sp} : {1'b0, st_q.b3_sp}, st_q.hl);
      unique case (st_q.b_mode[k])
        RSC_MODE_OFF: st_d.mode_out[k] = RSC_BMODE_OFF;
        RSC_MODE_PWM: st_d.mode_out[k] = RSC_BMODE_PWM;
        RSC_MODE_PFM: st_d.mode_out[k] = RSC_BMODE_PFM;
        RSC_MODE_APS: st_d.mode_out[k] = RSC_BMODE_APS;
        default:      st_d.mode_out[k] = st_q.mode_out[k];  // undefined code keeps the old mode
      endcase
      if (st_q.b_freq[k] != RSC_FREQ_RSVD) begin
        st_d.freq_out[k] = st_q.b_freq[k];
      end
    end
    for (int i = 0; i < 6; i++) begin
      st_d.ldo_mv[i] = ldo_mv(i, st_q.ldo_sp[i], st_q.vsel);
    end
    st_d.ldo_on = st_q.ldo_en;
    st_d.ldo_pd = ~st_q.ldo_en;
    st_d.irq    = |(st_q.flt & ~st_q.msk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset values are constants only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.b1_sp    <= RSC_B1_SP_RST;
      st_q.b2_sp    <= RSC_B2_SP_RST;
      st_q.b3_sp    <= RSC_B3_SP_RST;
      st_q.b_mode   <= {3{RSC_MODE_RST}};
      st_q.b_freq   <= {3{RSC_FREQ_RST}};
      st_q.freq_out <= {3{RSC_FREQ_RST}};
      st_q.mode_out <= {3{RSC_BMODE_APS}};
      st_q.b_phase  <= RSC_PHASE_RST;
      st_q.ldo_en   <= RSC_LDO_EN_RST;
      st_q.msk      <= RSC_MSK_RST;
      st_q.scp_en   <= RSC_SCP_RST;
      st_q.b_tgt    <= RSC_BUCK_INIT_MV;
      st_q.ldo_mv   <= RSC_LDO_RST_MV;
      st_q.ldo_pd   <= 6'h3F;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one ramp per buck
  for (genvar g = 0; g < 3; g++) begin : g_ramp
    rsc_dvs_ramp #(
      .INIT_MV     (RSC_BUCK_INIT_MV[g]),
      .STEP_MV     (RSC_MV_25),
      .STEP_CYCLES (DVS_CYCLES)
    ) u_ramp (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .target_mv (st_q.b_tgt[g]),
      .out_mv    (buck_vout_mv[g]),
      .ramping   (buck_ramping[g])
    );
  end

  assign reg_rdata      = st_q.rdata;
  assign buck_target_mv = st_q.b_tgt;
  assign buck_mode      = st_q.mode_out;
  assign buck_frequency = st_q.freq_out;
  assign buck_phase     = st_q.b_phase;
  assign buck_ilim      = st_q.b_ilim;
  assign ldo_target_mv  = st_q.ldo_mv;
  assign ldo_on         = st_q.ldo_on;
  assign ldo_pulldown   = st_q.ldo_pd;
  assign ldo_fault_irq  = st_q.irq;

endmodule // rsc_regulator_ctrl

/* tb/rsc_props.sv */
/* rsc_props: timing checks on the ports of rsc_regulator_ctrl.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ns
module rsc_props #(parameter int SCP_CYCLES = 20, parameter int DVS_CYCLES = 4) (
  input wire logic             mclk, arst_n, reg_wr, reg_rd, ldo_fault_irq, // clock, reset, strobes
  input wire logic [7:0]       reg_addr, reg_wdata, reg_rdata,              // register port
  input wire logic [2:0][11:0] buck_target_mv, buck_vout_mv,                // buck levels
  input wire logic [2:0][1:0]  buck_frequency,                              // frequency codes
  input wire logic [5:0]       ldo_on, ldo_pulldown                         // ldo lines
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs land two edges after the write is taken
  property p_b1_top; reg_wr && reg_addr == 8'h20 && reg_wdata[4:0] == 5'h1F |-> ##2 buck_target_mv[0] == 12'hCE4;
  endproperty
  a_b1_top: assert property (p_b1_top) else $error("buck1 top code");
  property p_b3; reg_wr && reg_addr == 8'h3C |-> ##2 buck_target_mv[2] == 12'd900 + 12'd50 * $past(reg_wdata[3:0], 2);
  endproperty
  a_b3: assert property (p_b3) else $error("buck3 decode");
  property p_en; reg_wr && reg_addr == 8'h70 |-> ##2 ldo_on[0] == $past(reg_wdata[4], 2); endproperty
  a_en: assert property (p_en) else $error("ldo enable");
  property p_freq; reg_wr && reg_addr == 8'h24 && reg_wdata[3:2] != 2'b11 |-> ##2 buck_frequency[0] == $past(reg_wdata[3:2], 2);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency");
  property p_mask; reg_wr && reg_addr == 8'h79 && reg_wdata[5:0] == 6'h3F |-> ##2 !ldo_fault_irq; endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  // discharge path always opposes the enable, so no window with both off
  property p_pd; ldo_pulldown == ~ldo_on; endproperty
  a_pd: assert property (p_pd) else $error("pulldown");
  property p_unm; reg_rd && reg_addr == 8'h50 |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_ramp; $changed(buck_vout_mv[0]) |=> $stable(buck_vout_mv[0]); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step");
endmodule // rsc_props
bind rsc_regulator_ctrl rsc_props #(.SCP_CYCLES(SCP_CYCLES), .DVS_CYCLES(DVS_CYCLES)) u_props (.mclk, .arst_n,
  .reg_wr, .reg_rd, .ldo_fault_irq, .reg_addr, .reg_wdata, .reg_rdata, .buck_target_mv, .buck_vout_mv,
  .buck_frequency, .ldo_on, .ldo_pulldown);

/* tb/rsc_host.sv */
/* rsc_host: register master on the far side of the block's port.
   assumes the bench drives mclk and calls wr and rd. */
`timescale 1ns/1ns
module rsc_host (
  input  wire logic       mclk,      // core clock
  output logic            reg_wr,    // write strobe
  output logic            reg_rd,    // read strobe
  output logic      [7:0] reg_addr,  // offset
  output logic      [7:0] reg_wdata, // data
  input  wire logic [7:0] reg_rdata  // read data
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // one-cycle write; released lines flip so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // data is taken one edge after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask
endmodule // rsc_host

/* tb/tb.sv */
/* tb: self-checking bench for rsc_regulator_ctrl driven by rsc_host.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ns
module tb;
  logic             mclk = 1'b0, arst_n = 1'b0, card_sel = 1'b0, reg_wr, reg_rd, ldo_fault_irq;
  logic [5:0]       lim = '0, ldo_on, ldo_pulldown;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0][11:0] buck_target_mv;
  logic [2:0][1:0]  buck_mode, buck_frequency;
  logic [5:0][11:0] ldo_target_mv;
  int               err_total = 0, samples_checked = 0;
  always #5 mclk = ~mclk;
  rsc_regulator_ctrl #(.SCP_CYCLES(20), .DVS_CYCLES(4)) DUT (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .buck2_startup_high(1'b0), .ldo_current_limit(lim), .card_voltage_select(card_sel), .buck_target_mv,
    .buck_vout_mv(), .buck_ramping(), .buck_mode, .buck_frequency, .buck_phase(), .buck_ilim(), .ldo_target_mv,
    .ldo_on, .ldo_pulldown, .ldo_fault_irq);
  rsc_host host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  ////////////////////////////////////////////////////////////////////////////
  // compares and closing report
  task automatic chk_bits(input string n, input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_mv(input string n, input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // writes each code, index 0..2 bucks then 3..8 ldos
  task automatic sweep(input logic [7:0] a, input int w, input int n, input int b, input int s);
    for (int c = 0; c < n; c++) begin
      host.wr(a, 8'(c));
      chk_mv("set point", w < 3 ? buck_target_mv[w] : ldo_target_mv[w-3], 12'(b + s * c));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_bits("mode", 8'(buck_mode), 8'h3F);
    chk_bits("freq", 8'(buck_frequency), 8'h15);
    chk_bits("pulldown", 8'(ldo_pulldown), 8'h3F);
    host.rd(8'h7A, d);
    chk_bits("shutdown enable", d, 8'h00);
    host.rd(8'h7B, d);
    chk_bits("range flag", 8'(d[7]), 8'h00);
    $display("reset test done");
  endtask
  task automatic t_decode;
    sweep(8'h20, 0, 30, 700, 25);
    sweep(8'h20, 0, 1, 700, 0);
    host.wr(8'h20, 8'h1E);
    chk_mv("buck1 jump", buck_target_mv[0], 12'd1800);
    host.wr(8'h20, 8'h1F);
    chk_mv("buck1 top", buck_target_mv[0], 12'd3300);
    sweep(8'h35, 1, 8, 1500, 50);
    sweep(8'h3C, 2, 16, 900, 50);
    sweep(8'h70, 3, 16, 1800, 100);
    sweep(8'h71, 4, 16, 800, 50);
    sweep(8'h72, 5, 16, 1800, 100);
    sweep(8'h73, 6, 16, 1800, 100);
    sweep(8'h74, 7, 4, 2850, 150);
    sweep(8'h75, 8, 4, 2850, 150);
    @(posedge mclk);
    card_sel <= 1'b1;
    repeat (5) @(posedge mclk);
    sweep(8'h75, 8, 3, 1800, 0);
    host.wr(8'h75, 8'h03);
    chk_mv("card low top", ldo_target_mv[5], 12'd1850);
    $display("decode test done");
  endtask
  task automatic t_modes;
    logic [7:0] m[4] = '{8'h00, 8'h01, 8'h03, 8'h08};
    logic [7:0] a[3] = '{8'h23, 8'h38, 8'h3F};
    for (int j = 0; j < 3; j++) begin
      for (int i = 0; i < 4; i++) begin
        host.wr(a[j], m[i]);
        chk_bits("mode", 8'(buck_mode[j]), 8'(i));
      end
    end
    host.wr(8'h38, 8'h02);
    chk_bits("undefined mode", 8'(buck_mode[1]), 8'h03);
    host.wr(8'h24, 8'h00);
    host.wr(8'h24, 8'h0C);
    chk_bits("reserved freq", 8'(buck_frequency[0]), 8'h00);
    host.wr(8'h35, 8'hFF);
    host.rd(8'h35, d);
    chk_bits("unused bits", d, 8'h07);
    host.rd(8'h50, d);
    chk_bits("unmapped", d, 8'h00);
    $display("mode test done");
  endtask
  task automatic t_ldo;
    for (int i = 0; i < 6; i++) begin
      host.wr(8'(8'h70 + i), 8'h10);
      chk_bits("on", {ldo_on[i], ldo_pulldown[i]}, 8'h02);
      host.wr(8'(8'h70 + i), 8'h00);
      chk_bits("off", {ldo_on[i], ldo_pulldown[i]}, 8'h01);
    end
    host.wr(8'h70, 8'h13);
    host.rd(8'h70, d);
    chk_bits("control", d, 8'h13);
    $display("ldo test done");
  endtask
  // overload on LDO one: flag, request, then timed shutdown
  task automatic t_fault;
    int n;
    host.wr(8'h7A, 8'h01);
    host.wr(8'h79, 8'h3E);
    host.wr(8'h70, 8'h10);
    @(posedge mclk);
    lim <= 6'h01;
    #1;
    for (n = 0; n < 12 && ldo_fault_irq !== 1'b1; n++) #10;
    chk_bits("request", 8'(ldo_fault_irq), 8'h01);
    if (n >= 12) summarize;
    for (n = 0; n < 40 && ldo_on[0] !== 1'b0; n++) #10;
    chk_bits("shutdown", 8'(ldo_on[0]), 8'h00);
    if (n >= 40) summarize;
    @(posedge mclk);
    lim <= 6'h00;
    repeat (6) @(posedge mclk);
    host.rd(8'h78, d);
    chk_bits("flag held", d, 8'h01);
    host.wr(8'h79, 8'h3F);
    chk_bits("masked", 8'(ldo_fault_irq), 8'h00);
    host.wr(8'h78, 8'h01);
    host.rd(8'h78, d);
    chk_bits("flag cleared", d, 8'h00);
    $display("fault test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    t_reset;
    t_decode;
    t_modes;
    t_ldo;
    t_fault;
    summarize;
  end
endmodule // tb
